// *** dv/host_model.sv ***
/*
 * Host side model: config cycles and memory requests towards the block.
 * Assumes its tasks are entered at a falling edge of i_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module host_model (
   input wire logic i_clk,
   input wire logic i_cfg_rvalid,
   input wire logic [31:0] i_cfg_rdata,
   output logic o_cfg_wr,
   output logic o_cfg_rd,
   output logic [7:0] o_cfg_addr,
   output logic [3:0] o_cfg_be,
   output logic [31:0] o_cfg_wdata,
   output logic o_req_valid,
   output logic o_req_write,
   output logic [63:0] o_req_addr
);
   // quiet bus at time zero
   initial begin
      o_cfg_wr = 1'b0;
      o_cfg_rd = 1'b0;
      o_cfg_addr = 8'h00;
      o_cfg_be = 4'h0;
      o_cfg_wdata = 32'h0000_0000;
      o_req_valid = 1'b0;
      o_req_write = 1'b0;
      o_req_addr = 64'h0;
   end
   // released lines show the inverse so stale values are never trusted
   task automatic cfg_write(input logic [7:0] a, input logic [3:0] be,
         input logic [31:0] d);
      o_cfg_wr = 1'b1;
      o_cfg_addr = a;
      o_cfg_be = be;
      o_cfg_wdata = d;
      @(negedge i_clk);
      o_cfg_wr = 1'b0;
      o_cfg_addr = ~a;
      o_cfg_be = ~be;
      o_cfg_wdata = ~d;
   endtask
   // answer is registered, so it is looked at one edge after the request
   task automatic cfg_read(input logic [7:0] a, output logic v,
         output logic [31:0] d);
      o_cfg_rd = 1'b1;
      o_cfg_addr = a;
      @(negedge i_clk);
      o_cfg_rd = 1'b0;
      o_cfg_addr = ~a;
      v = i_cfg_rvalid;
      d = i_cfg_rdata;
   endtask
   // one request pulse; caller samples decode outputs on return
   task automatic mem_req(input logic [63:0] a, input logic w);
      o_req_valid = 1'b1;
      o_req_write = w;
      o_req_addr = a;
      @(negedge i_clk);
      o_req_valid = 1'b0;
      o_req_write = ~w;
      o_req_addr = ~a;
   endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
/*
 * Self-checking bench for the window decode block: reset values, readback,
 * steering corners and a seeded random mix. Assumes the host model file.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam int LIMIT = 20000;
   localparam logic [7:0] OFFS [8] = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h1C,
      8'h20, 8'h24, 8'h28};
   logic clk, reset, sel, cfg_wr, cfg_rd, cfg_rvalid, req_valid, req_write;
   logic ctl_hit, rsv_hit, vcfg_hit, vmem_hit, req_wr_q, ddr_cs;
   logic [7:0] cfg_addr;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata, win_off, op;
   logic [63:0] req_addr, rn;
   logic [4:0] size;
   logic [15:0] ddr_row;
   logic [14:0] ddr_col;
   logic [2:0] ddr_bank;
   logic [31:0] raw [8];
   int fail_count, n_compared, cycles;
   integer seed = 32'hB087;

   host_model host (.i_clk(clk), .i_cfg_rvalid(cfg_rvalid),
      .i_cfg_rdata(cfg_rdata), .o_cfg_wr(cfg_wr), .o_cfg_rd(cfg_rd),
      .o_cfg_addr(cfg_addr), .o_cfg_be(cfg_be), .o_cfg_wdata(cfg_wdata),
      .o_req_valid(req_valid), .o_req_write(req_write),
      .o_req_addr(req_addr));
   gpu_bar_window_decode dut (.i_clk(clk), .i_reset(reset),
      .i_cfg_wr(cfg_wr), .i_cfg_rd(cfg_rd), .i_cfg_addr(cfg_addr),
      .i_cfg_be(cfg_be), .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(cfg_rdata),
      .o_cfg_rvalid(cfg_rvalid), .i_gmem_data_select(sel),
      .i_vmem_size_log2(size), .i_req_valid(req_valid),
      .i_req_write(req_write), .i_req_addr(req_addr), .o_ctl_hit(ctl_hit),
      .o_rsv_hit(rsv_hit), .o_vmem_cfg_hit(vcfg_hit),
      .o_vmem_mem_hit(vmem_hit), .o_req_write(req_wr_q),
      .o_win_offset(win_off), .o_ddr_cs(ddr_cs), .o_ddr_row(ddr_row),
      .o_ddr_col(ddr_col), .o_ddr_bank(ddr_bank));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic print_verdict;
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // a hang is cut short here and still reaches the verdict
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fail_count++;
         $display("BAD %0t timeout", $time);
         print_verdict;
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp,
         input string what);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask

   // video mask from the current size; size stays within 4..29
   function automatic logic [63:0] vmask();
      return ~((64'h1 << size) - 64'h1);
   endfunction

   function automatic logic [31:0] exp_rd(input int i);
      case (i)
         0: exp_rd = raw[0] & 32'h0000_0002;
         1, 5: exp_rd = (raw[i] & 32'hFFFC_0000) | 32'h0000_0004;
         3: exp_rd = (raw[3] & vmask()) | 32'h0000_0004;
         2, 4, 6: exp_rd = raw[i];
         default: exp_rd = 32'h0000_0000;
      endcase
   endfunction

   // shadow follows byte enables; the unmapped slot never changes
   task automatic wr(input int i, input logic [3:0] be, input logic [31:0] d);
      logic [31:0] m;
      logic [63:0] vm;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      vm = vmask();
      // video low dword only takes bits above the size at write time
      if (i == 3) m = m & vm[31:0];
      host.cfg_write(OFFS[i], be, d);
      if (i < 7) raw[i] = (raw[i] & ~m) | (d & m);
      @(negedge clk);
   endtask

   task automatic rd_chk(input int i);
      logic v;
      logic [31:0] d;
      host.cfg_read(OFFS[i], v, d);
      chk(v, 1'b1, "rvalid");
      chk(d, exp_rd(i), "rdata");
      @(negedge clk);
   endtask

   task automatic req(input logic [63:0] a, input logic w);
      logic c, r, v;
      logic [63:0] cb, rb, vb, off;
      cb = {raw[2], raw[1] & 32'hFFFC_0000};
      rb = {raw[6], raw[5] & 32'hFFFC_0000};
      vb = {raw[4], raw[3]} & vmask();
      c = raw[0][1] && (a[63:18] == cb[63:18]);
      r = raw[0][1] && !c && (a[63:18] == rb[63:18]);
      v = raw[0][1] && !c && !r && ((a & vmask()) == vb);
      off = (c || r) ? {46'h0, a[17:0]} : v ? (a & ~vmask()) : 64'h0;
      host.mem_req(a, w);
      chk(ctl_hit, c, "ctl hit");
      chk(rsv_hit, r, "rsv hit");
      chk(vcfg_hit, v & !sel, "vcfg hit");
      chk(vmem_hit, v & sel, "vmem hit");
      chk(ddr_cs, v & sel, "cs");
      chk(win_off, off[31:0], "offset");
      chk(req_wr_q, w, "write");
      if (v & sel) chk({ddr_row, ddr_col, ddr_bank},
         {off[36:21], off[17:3], off[20:18]}, "ddr");
      @(negedge clk);
   endtask

   // kinds: control, reserved, video, near miss on the high dword, random
   function automatic logic [63:0] pick(input int k, input logic [63:0] x);
      case (k)
         0: pick = {raw[2], raw[1] & 32'hFFFC_0000} | (x & 64'h3_FFFF);
         1: pick = {raw[6], raw[5] & 32'hFFFC_0000} | (x & 64'h3_FFFF);
         2: pick = ({raw[4], raw[3]} & vmask()) | (x & ~vmask());
         3: pick = {raw[2] ^ 32'h0000_0001, raw[1] & 32'hFFFC_0000};
         default: pick = x;
      endcase
   endfunction

   initial begin
      reset = 1'b1;
      sel = 1'b0;
      size = 5'h04;
      fail_count = 0;
      n_compared = 0;
      cycles = 0;
      foreach (raw[i]) raw[i] = 32'h0000_0000;
      repeat (16) @(negedge clk);
      reset = 1'b0;
      for (int i = 0; i < 8; i++) rd_chk(i);
      $display("test reset_values done");
      for (int i = 1; i < 7; i++) begin
         wr(i, 4'hF, 32'hFFFF_FFFF);
         rd_chk(i);
      end
      wr(7, 4'hF, 32'hFFFF_FFFF);
      rd_chk(7);
      size = 5'h1D;
      rd_chk(3);
      $display("test readback done");
      sel = 1'b1;
      wr(3, 4'hF, 32'h2000_0000);
      wr(4, 4'hF, 32'h0000_0001);
      req(64'h1_2000_0008, 1'b1);
      wr(0, 4'hF, 32'hFFFF_FFFF);
      req(64'h1_3FFF_FFF8, 1'b0);
      req(64'h1_2004_0008, 1'b1);
      sel = 1'b0;
      req(64'h1_2004_0008, 1'b1);
      $display("test steering done");
      for (int n = 0; n < 400; n++) begin
         op = $random(seed);
         rn = {$random(seed), $random(seed)};
         if (op[3:0] == 4'h0) size = 5'h04 + (op[8:4] % 5'h1A);
         sel = op[9];
         if (op[12:10] < 3'h2) wr(op[15:13], op[19:16], rn[31:0]);
         else if (op[12:10] == 3'h2) rd_chk(op[15:13]);
         else req(pick(op[18:16] % 5, rn), op[20]);
      end
      $display("test random_mix done");
      print_verdict;
   end
endmodule
`default_nettype wire

// *** verilog/gpu_bar_defs.svh ***
/*
 * Constants for the graphics function's window base registers: offsets,
 * field positions, reset values and the address split used towards the
 * memory controller. Assumes a 256-byte configuration space, dword access.
 */
`ifndef GPU_BAR_DEFS_SVH
`define GPU_BAR_DEFS_SVH

// configuration header offsets
`define CFG_CMD_OFF 8'h04
`define CFG_CTL_LO_OFF 8'h10
`define CFG_CTL_HI_OFF 8'h14
`define CFG_VMEM_LO_OFF 8'h18
`define CFG_VMEM_HI_OFF 8'h1C
`define CFG_RSV_LO_OFF 8'h20
`define CFG_RSV_HI_OFF 8'h24

// command register: memory space enable
`define CMD_MSE_BIT 1

// window base low and high dword fields
`define BAR_TYPE_FIXED 32'h0000_0004
`define BAR_LO_RESET 32'h0000_0004
`define BAR_HI_RESET 32'h0000_0000
`define BAR_FIXED_WMASK 32'hFFFC_0000
`define BAR_ALL_ONES 32'hFFFF_FFFF
`define BAR_TYPE_LSBS 4

// video window size as log2 of bytes
`define VMEM_LOG2_MIN 5'h04
`define VMEM_LOG2_MAX 5'h1D

// byte offset split towards the memory controller
`define DDR_COL_LSB 3
`define DDR_BANK_LSB 18
`define DDR_ROW_LSB 21
`define DDR_ROW_W 16
`define DDR_COL_W 15
`define DDR_BANK_W 3

`endif

// *** verilog/gpu_bar_pkg.sv ***
/*
 * Types shared by the window decode modules.
 * Assumes gpu_bar_defs.svh is compiled alongside.
 */
package gpu_bar_pkg;
   typedef logic [63:0] addr64_t;
   // where a request that hit one of the windows is sent
   typedef enum logic [2:0] {
      TGT_NONE,
      TGT_CTL,
      TGT_VCFG,
      TGT_VMEM,
      TGT_RSV
   } target_t;
endpackage

// *** verilog/gpu_bar_window_decode.sv ***
/*
 * Window base registers of the graphics function and the steering of
 * requests that hit its windows. Assumes config cycles and memory
 * requests arrive synchronous to i_clk; the data selector and the video
 * window size come from bridge logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "gpu_bar_defs.svh"

// Function
// RULE1: control base low bits 31..18 are writable and read back.
// RULE2: control base bits 17..4 read zero, a 256KB window.
// RULE3: bit 3 of each base reads zero, not prefetchable.
// RULE4: bits 2..1 of each base read 10b, a 64-bit base.
// RULE5: bit 0 of each base reads zero, memory space.
// RULE6: control base upper dword at 14h is fully writable, used in decode.
// RULE7: video base writable above configurable size; lower bits read zero.
// RULE8: firmware sets the video window size, never above 512MB.
// RULE9: video base upper dword at 1Ch is fully writable.
// RULE10: reserved base low bits 31..18 are writable and read back.
// RULE11: reserved base bits 17..4 read zero, reported as 256KB.
// RULE12: reserved base upper dword at 24h is fully writable.
// RULE13: controller registers and video memory share the one video window.
// RULE14: selector zero sends every video window hit to controller registers.
// RULE15: selector one sends video window hits to memory as normal accesses.
// RULE16: memory accesses use one chip select, 16 row, 15 column, 3 bank.
// RULE17: windows decode only while memory space enable is set.
// RULE18: writes to fixed size, type and space bits are ignored.
// RULE19: a hit needs equality over the writable bits of the 64-bit base.
module gpu_bar_window_decode
   import gpu_bar_pkg::*;
#(
   parameter int ROW_W = `DDR_ROW_W,
   parameter int COL_W = `DDR_COL_W,
   parameter int BANK_W = `DDR_BANK_W
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_cfg_wr,
   input wire logic i_cfg_rd,
   input wire logic [7:0] i_cfg_addr,
   input wire logic [3:0] i_cfg_be,
   input wire logic [31:0] i_cfg_wdata,
   output logic [31:0] o_cfg_rdata,
   output logic o_cfg_rvalid,
   input wire logic i_gmem_data_select,
   input wire logic [4:0] i_vmem_size_log2,
   input wire logic i_req_valid,
   input wire logic i_req_write,
   input wire logic [63:0] i_req_addr,
   output logic o_ctl_hit,
   output logic o_rsv_hit,
   output logic o_vmem_cfg_hit,
   output logic o_vmem_mem_hit,
   output logic o_req_write,
   output logic [31:0] o_win_offset,
   output logic o_ddr_cs,
   output logic [ROW_W-1:0] o_ddr_row,
   output logic [COL_W-1:0] o_ddr_col,
   output logic [BANK_W-1:0] o_ddr_bank
);

   logic mse_reg;
   logic [31:0] ctl_lo_reg, ctl_hi_reg;
   logic [31:0] vmem_lo_reg, vmem_hi_reg;
   logic [31:0] rsv_lo_reg, rsv_hi_reg;
   logic [4:0] vmem_log2;
   logic [31:0] vmem_wmask;
   logic [31:0] rdata_next;
   target_t target_next;
   logic [31:0] offset_next;

   window_if ctl_win ();
   window_if vmem_win ();
   window_if rsv_win ();

   // byte-enable merge; bits outside wmask keep their stored value
   function automatic logic [31:0] merge_be(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be,
                                            input logic [31:0] wmask);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
      return (old & ~m) | (wd & m);
   endfunction

   // firmware may program out of range; clamp so the window stays sane
   always_comb begin
      if (i_vmem_size_log2 > `VMEM_LOG2_MAX) begin
         vmem_log2 = `VMEM_LOG2_MAX; // RULE8
      end else if (i_vmem_size_log2 < `VMEM_LOG2_MIN) begin
         vmem_log2 = `VMEM_LOG2_MIN;
      end else begin
         vmem_log2 = i_vmem_size_log2;
      end
      vmem_wmask = `BAR_ALL_ONES << vmem_log2; // RULE7
   end

   // command register: only memory space enable is writable
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         mse_reg <= 1'b0;
      end else if (i_cfg_wr && i_cfg_addr == `CFG_CMD_OFF
                   && i_cfg_be[0]) begin
         mse_reg <= i_cfg_wdata[`CMD_MSE_BIT];
      end
   end

   // control window base pair
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         ctl_lo_reg <= `BAR_LO_RESET;
         ctl_hi_reg <= `BAR_HI_RESET;
      end else if (i_cfg_wr) begin
         if (i_cfg_addr == `CFG_CTL_LO_OFF) begin
            ctl_lo_reg <= merge_be(ctl_lo_reg, i_cfg_wdata, i_cfg_be,
                                   `BAR_FIXED_WMASK); // RULE1 RULE18
         end
         if (i_cfg_addr == `CFG_CTL_HI_OFF) begin
            ctl_hi_reg <= merge_be(ctl_hi_reg, i_cfg_wdata, i_cfg_be,
                                   `BAR_ALL_ONES); // RULE6
         end
      end
   end

   // video window base pair; low part only takes bits above the current
   // size, and is masked again on read and compare since the size may move
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         vmem_lo_reg <= `BAR_LO_RESET;
         vmem_hi_reg <= `BAR_HI_RESET;
      end else if (i_cfg_wr) begin
         if (i_cfg_addr == `CFG_VMEM_LO_OFF) begin
            vmem_lo_reg <= merge_be(vmem_lo_reg, i_cfg_wdata, i_cfg_be,
                                    vmem_wmask); // RULE7 RULE18
         end
         if (i_cfg_addr == `CFG_VMEM_HI_OFF) begin
            vmem_hi_reg <= merge_be(vmem_hi_reg, i_cfg_wdata, i_cfg_be,
                                    `BAR_ALL_ONES); // RULE9
         end
      end
   end

   // reserved window base pair
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         rsv_lo_reg <= `BAR_LO_RESET;
         rsv_hi_reg <= `BAR_HI_RESET;
      end else if (i_cfg_wr) begin
         if (i_cfg_addr == `CFG_RSV_LO_OFF) begin
            rsv_lo_reg <= merge_be(rsv_lo_reg, i_cfg_wdata, i_cfg_be,
                                   `BAR_FIXED_WMASK); // RULE10 RULE18
         end
         if (i_cfg_addr == `CFG_RSV_HI_OFF) begin
            rsv_hi_reg <= merge_be(rsv_hi_reg, i_cfg_wdata, i_cfg_be,
                                   `BAR_ALL_ONES); // RULE12
         end
      end
   end

   // read mux; fixed low bits always come from the constant, never a flop
   always_comb begin
      unique case (i_cfg_addr)
         `CFG_CMD_OFF: rdata_next = {30'h0, mse_reg, 1'b0};
         `CFG_CTL_LO_OFF: rdata_next = (ctl_lo_reg & `BAR_FIXED_WMASK)
            | `BAR_TYPE_FIXED; // RULE2 RULE3 RULE4 RULE5
         `CFG_CTL_HI_OFF: rdata_next = ctl_hi_reg;
         `CFG_VMEM_LO_OFF: rdata_next = (vmem_lo_reg & vmem_wmask)
            | `BAR_TYPE_FIXED; // RULE7 RULE3 RULE4 RULE5
         `CFG_VMEM_HI_OFF: rdata_next = vmem_hi_reg;
         `CFG_RSV_LO_OFF: rdata_next = (rsv_lo_reg & `BAR_FIXED_WMASK)
            | `BAR_TYPE_FIXED; // RULE11 RULE3 RULE4 RULE5
         `CFG_RSV_HI_OFF: rdata_next = rsv_hi_reg;
         default: rdata_next = 32'h0000_0000; // unmapped reads as zero
      endcase
   end

   // read answer one cycle after the strobe
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_cfg_rdata <= 32'h0000_0000;
         o_cfg_rvalid <= 1'b0;
      end else begin
         o_cfg_rvalid <= i_cfg_rd;
         if (i_cfg_rd) begin
            o_cfg_rdata <= rdata_next;
         end
      end
   end

   // comparators see the full 64-bit base over the writable bits only
   assign ctl_win.base = {ctl_hi_reg, ctl_lo_reg & `BAR_FIXED_WMASK};
   assign ctl_win.mask = {`BAR_ALL_ONES, `BAR_FIXED_WMASK}; // RULE19
   assign ctl_win.addr = i_req_addr;
   assign vmem_win.base = {vmem_hi_reg, vmem_lo_reg & vmem_wmask};
   assign vmem_win.mask = {`BAR_ALL_ONES, vmem_wmask}; // RULE19
   assign vmem_win.addr = i_req_addr;
   assign rsv_win.base = {rsv_hi_reg, rsv_lo_reg & `BAR_FIXED_WMASK};
   assign rsv_win.mask = {`BAR_ALL_ONES, `BAR_FIXED_WMASK}; // RULE19
   assign rsv_win.addr = i_req_addr;

   window_match u_ctl_match (.win(ctl_win.matcher));
   window_match u_vmem_match (.win(vmem_win.matcher));
   window_match u_rsv_match (.win(rsv_win.matcher));

   // target select; overlapping windows resolve control, reserved, video
   always_comb begin
      target_next = TGT_NONE;
      offset_next = 32'h0000_0000;
      if (i_req_valid && mse_reg) begin // RULE17
         if (ctl_win.hit) begin
            target_next = TGT_CTL;
            offset_next = i_req_addr[31:0] & ~`BAR_FIXED_WMASK;
         end else if (rsv_win.hit) begin
            target_next = TGT_RSV;
            offset_next = i_req_addr[31:0] & ~`BAR_FIXED_WMASK;
         end else if (vmem_win.hit) begin
            // one window, two destinations chosen by the selector
            target_next = i_gmem_data_select ? TGT_VMEM : TGT_VCFG;
            offset_next = i_req_addr[31:0] & ~vmem_wmask; // RULE13 RULE14
         end
      end
   end

   // registered hit strobes, one cycle after the request
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_ctl_hit <= 1'b0;
         o_rsv_hit <= 1'b0;
         o_vmem_cfg_hit <= 1'b0;
         o_vmem_mem_hit <= 1'b0;
      end else begin
         o_ctl_hit <= (target_next == TGT_CTL);
         o_rsv_hit <= (target_next == TGT_RSV);
         o_vmem_cfg_hit <= (target_next == TGT_VCFG); // RULE14
         o_vmem_mem_hit <= (target_next == TGT_VMEM); // RULE15
      end
   end

   // offset and direction travel with the strobes
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_win_offset <= 32'h0000_0000;
         o_req_write <= 1'b0;
      end else begin
         o_win_offset <= offset_next;
         o_req_write <= i_req_valid & i_req_write;
      end
   end

   // memory address split; chip select only for plain memory accesses
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_ddr_cs <= 1'b0;
         o_ddr_row <= '0;
         o_ddr_col <= '0;
         o_ddr_bank <= '0;
      end else begin
         o_ddr_cs <= (target_next == TGT_VMEM); // RULE16
         o_ddr_col <= offset_next[`DDR_COL_LSB +: COL_W];
         o_ddr_bank <= offset_next[`DDR_BANK_LSB +: BANK_W];
         o_ddr_row <= ROW_W'({32'h0, offset_next} >> `DDR_ROW_LSB);
      end
   end

   // ---- checks ----
   property p_ctl_lo_write;
      @(posedge i_clk) disable iff (i_reset)
      (i_cfg_wr && i_cfg_addr == `CFG_CTL_LO_OFF && i_cfg_be == 4'hF)
      |=> ctl_lo_reg[31:18] == $past(i_cfg_wdata[31:18]);
   endproperty
   a_ctl_lo_write: assert property (p_ctl_lo_write) // RULE1
      else $error("control base low bits not written");

   property p_fixed_low_read;
      @(posedge i_clk) disable iff (i_reset)
      (i_cfg_rd && (i_cfg_addr == `CFG_CTL_LO_OFF
                    || i_cfg_addr == `CFG_RSV_LO_OFF))
      |=> o_cfg_rvalid && o_cfg_rdata[17:0] == 18'h00004;
   endproperty
   a_fixed_low_read: assert property (p_fixed_low_read) // RULE2
      else $error("fixed low bits of base read wrong");

   property p_vmem_type_read;
      @(posedge i_clk) disable iff (i_reset)
      (i_cfg_rd && i_cfg_addr == `CFG_VMEM_LO_OFF)
      |=> o_cfg_rdata[3:0] == 4'h4
          && (o_cfg_rdata & ~$past(vmem_wmask)) == 32'h0000_0004;
   endproperty
   a_vmem_type_read: assert property (p_vmem_type_read) // RULE7
      else $error("video base size or type bits read wrong");

   property p_hi_write;
      @(posedge i_clk) disable iff (i_reset)
      (i_cfg_wr && i_cfg_be == 4'hF && i_cfg_addr == `CFG_CTL_HI_OFF)
      |=> ctl_hi_reg == $past(i_cfg_wdata);
   endproperty
   a_hi_write: assert property (p_hi_write) // RULE6
      else $error("control base upper dword not held");

   property p_rsv_hi_read;
      @(posedge i_clk) disable iff (i_reset)
      (i_cfg_wr && i_cfg_be == 4'hF && i_cfg_addr == `CFG_RSV_HI_OFF)
      ##1 !(i_cfg_wr && i_cfg_addr == `CFG_RSV_HI_OFF)
      ##1 (i_cfg_rd && i_cfg_addr == `CFG_RSV_HI_OFF && !i_cfg_wr)
      |=> o_cfg_rdata == $past(i_cfg_wdata, 3);
   endproperty
   a_rsv_hi_read: assert property (p_rsv_hi_read) // RULE12
      else $error("reserved base upper dword readback wrong");

   property p_sel_cfg;
      @(posedge i_clk) disable iff (i_reset)
      o_vmem_cfg_hit |-> !$past(i_gmem_data_select) && !o_ddr_cs;
   endproperty
   a_sel_cfg: assert property (p_sel_cfg) // RULE14
      else $error("config hit with data selector set");

   property p_sel_mem;
      @(posedge i_clk) disable iff (i_reset)
      o_vmem_mem_hit |-> $past(i_gmem_data_select) && o_ddr_cs;
   endproperty
   a_sel_mem: assert property (p_sel_mem) // RULE15
      else $error("memory hit without selector or chip select");

   property p_mse_gate;
      @(posedge i_clk) disable iff (i_reset)
      (o_ctl_hit || o_rsv_hit || o_vmem_cfg_hit || o_vmem_mem_hit)
      |-> $past(mse_reg);
   endproperty
   a_mse_gate: assert property (p_mse_gate) // RULE17
      else $error("window decoded with memory space disabled");

   property p_ctl_match;
      @(posedge i_clk) disable iff (i_reset)
      o_ctl_hit |-> $past(i_req_addr[63:18]) ==
         $past({ctl_hi_reg, ctl_lo_reg[31:18]});
   endproperty
   a_ctl_match: assert property (p_ctl_match) // RULE19
      else $error("control hit without base match");

   property p_cs_only_mem;
      @(posedge i_clk) disable iff (i_reset)
      o_ddr_cs |-> o_vmem_mem_hit && !o_ctl_hit && !o_rsv_hit;
   endproperty
   a_cs_only_mem: assert property (p_cs_only_mem) // RULE16
      else $error("chip select outside a memory access");

   property p_ro_bits_kept;
      @(posedge i_clk) disable iff (i_reset)
      (i_cfg_wr && i_cfg_addr == `CFG_RSV_LO_OFF)
      |=> rsv_lo_reg[17:0] == 18'h00004;
   endproperty
   a_ro_bits_kept: assert property (p_ro_bits_kept) // RULE18
      else $error("fixed bits of reserved base changed");

endmodule
`default_nettype wire

// *** verilog/window_if.sv ***
/*
 * Carrier between the decode top and one window comparator.
 * Assumes a purely combinational comparator on the matcher side.
 */
`timescale 1ns/1ns
`default_nettype none
interface window_if;
   import gpu_bar_pkg::*;
   addr64_t base;
   addr64_t mask;
   addr64_t addr;
   logic hit;
   modport owner (output base, output mask, output addr, input hit);
   modport matcher (input base, input mask, input addr, output hit);
endinterface
`default_nettype wire

// *** verilog/window_match.sv ***
/*
 * One window comparator: address equals base over the masked bits.
 * Assumes base and mask are stable while the address is looked up.
 */
`timescale 1ns/1ns
`default_nettype none
module window_match
   import gpu_bar_pkg::*;
(
   window_if.matcher win
);
   // only the writable base bits take part in the compare
   assign win.hit = (((win.addr ^ win.base) & win.mask) == 64'h0);
endmodule
`default_nettype wire
